// ===== src/lcdsub_regs.vh
/*
 * Command codes, field positions and reset values for the sub-table
 * command decoder. Assumes inclusion by bare name from the design files.
 */
`ifndef LCDSUB_REGS_VH
`define LCDSUB_REGS_VH

`define LCDSUB_CMD_SUB_ENTER   8'h70
`define LCDSUB_CMD_SUB_EXIT    8'h71
`define LCDSUB_CMD_PART_ON     8'h40
`define LCDSUB_CMD_ACTIVATE    8'hA0
`define LCDSUB_CMD_SOFT_RESET  8'hE2
`define LCDSUB_CMD_COL_HI      4'h1
`define LCDSUB_CMD_COL_LO      4'h0
`define LCDSUB_HI_B1_START     4'h0
`define LCDSUB_HI_B2_START     4'hC
`define LCDSUB_TOP3_B1_COUNT   3'h1
`define LCDSUB_TOP3_B2_COUNT   3'h7
`define LCDSUB_HI_LEVEL_UP     4'h8
`define LCDSUB_HI_LEVEL_LO     4'h9
`define LCDSUB_HI_LINV         4'h5
`define LCDSUB_HI_BIAS         4'hB
`define LCDSUB_TOP5_BOOST      5'h05
`define LCDSUB_TOP7_RMW        7'h74
`define LCDSUB_TOP7_SUPPLY     7'h12
`define LCDSUB_TOP7_WAVE       7'h11

`define LCDSUB_RST_CONTRAST    8'hFF
`define LCDSUB_RST_BIAS        4'h8
`define LCDSUB_RST_BOOST       3'h4
`define LCDSUB_RST_LINV        4'h0
`define LCDSUB_FULL_UNITS      5'h10
`define LCDSUB_LINES_PER_UNIT  8'h08
`define LCDSUB_LAST_UNIT       5'h0F
`define LCDSUB_LAST_COLUMN     8'h83
`define LCDSUB_BOOST_MIN       4'h2
`define LCDSUB_BOOST_MAX       4'h6

`endif

// ===== src/lcdsub_duty.v
/*
 * Works out the active unit count and memory page map of partial display.
 * Assumes the block fields come from registers on the same clock.
 */
`timescale 1ns/1ps
module lcdsub_duty (
    input  wire [3:0] b1_start_i,
    input  wire [4:0] b1_count_i,
    input  wire [3:0] b2_start_i,
    input  wire [4:0] b2_count_i,
    input  wire       partial_i,
    output reg  [4:0] units_o,
    output reg  [7:0] duty_lines_o,
    output reg  [4:0] b2_page_o,
    output reg        b2_used_o
);
`include "lcdsub_regs.vh"
    reg [5:0] sum;
    always @* begin
        sum = 6'h00;
        b2_used_o = 1'b0;
        b2_page_o = 5'h00;
        if (!partial_i) begin
            units_o = `LCDSUB_FULL_UNITS;
        end else if (b1_start_i == 4'h0 && b1_count_i == `LCDSUB_FULL_UNITS) begin
            units_o = `LCDSUB_FULL_UNITS;
        end else if (b2_start_i == 4'h0 && b2_count_i == 5'h00) begin
            units_o = b1_count_i;
        end else begin
            sum = {1'b0, b1_count_i} + {1'b0, b2_count_i};
            units_o = (sum > 6'h10) ? `LCDSUB_FULL_UNITS : sum[4:0];
            b2_used_o = 1'b1;
            b2_page_o = b1_count_i;
        end
        // duty is one over eight lines per unit
        duty_lines_o = {units_o, 3'b000};
    end
endmodule // lcdsub_duty

// ===== src/lcdsub_decoder.v
/*
 * Command decoder for the sub instruction table and related main commands.
 * Assumes bytes arrive as one-cycle strobes from the bus front end on clk_i.
 */
// What this block does
// - Byte 0x70 enters sub table, 0x71 returns to main table.
// - Rows form sixteen units of eight lines each.
// - Decode block starts and counts at 0x00, 0x20, 0xC0, 0xE0.
// - Block settings stay inactive until partial-display-on 0x40.
// - Partial duty is one over eight times active units.
// - Start zero with count sixteen gives full 1/128 and ignores block two.
// - Zero start and count for block two shows block one alone.
// - Memory maps contiguously from page zero, gaps ignored.
// - Partial changes only duty and area; host stops waveform first.
// - Line inversion count in sub mode, applied on activation.
// - Contrast loaded as two nibbles in sub mode.
// - New contrast applies only after activation byte 0xA0.
// - Bias 0xB0 field: 0..7 give 1/4..1/11, top bit 1/12.
// - Booster field 000..011 gives 2x..5x, 1xx gives 6x, shifted down.
// - Read-modify-write: writes advance column, reads do not.
// - End with flag set restores column from mode entry.
// - Soft reset 0xE2 restores defaults except supply and waveform flags, memory untouched.
// - Supply on enables booster, regulator, follower with oscillator running.
// - 0x22 plus flag stops or enables the drive waveform.
`timescale 1ns/1ps
module lcdsub_decoder (
    input  wire       clk_i,
    input  wire       nrst_i,
    input  wire       cmd_valid_i,
    input  wire [7:0] cmd_byte_i,
    input  wire       command_data_select_i,
    input  wire       mem_write_i,
    input  wire       mem_read_i,
    input  wire       osc_running_i,
    input  wire [2:0] fitted_stages_i,
    output reg        sub_mode_o,
    output reg        partial_o,
    output reg  [3:0] b1_start_o,
    output reg  [4:0] b1_count_o,
    output reg  [3:0] b2_start_o,
    output reg  [4:0] b2_count_o,
    output wire [4:0] active_units_o,
    output wire [7:0] duty_lines_o,
    output wire [4:0] b2_first_page_o,
    output wire       b2_used_o,
    output reg  [7:0] contrast_level_setting_o,
    output reg  [3:0] line_inv_o,
    output reg  [3:0] bias_code_o,
    output reg  [2:0] boost_mult_o,
    output reg        rmw_o,
    output reg  [7:0] column_o,
    output reg        supply_on_o,
    output reg        booster_en_o,
    output reg        regulator_en_o,
    output reg        follower_en_o,
    output reg        wave_on_o,
    output reg        soft_reset_o
);
`include "lcdsub_regs.vh"
    reg [3:0] b1s_q, b2s_q;
    reg [4:0] b1c_q, b2c_q;
    reg [7:0] lvl_pend_q, col_save_q;
    reg [3:0] linv_pend_q;
    reg [2:0] boost_code_q;
    reg       osc_meta_q;
    reg       osc_sync_q;
    wire      cmd = cmd_valid_i && !command_data_select_i;
    wire      dat = cmd_valid_i && command_data_select_i;
    wire [7:0] b = cmd_byte_i;

    lcdsub_duty u_duty (
        .b1_start_i   (b1_start_o),
        .b1_count_i   (b1_count_o),
        .b2_start_i   (b2_start_o),
        .b2_count_i   (b2_count_o),
        .partial_i    (partial_o),
        .units_o      (active_units_o),
        .duty_lines_o (duty_lines_o),
        .b2_page_o    (b2_first_page_o),
        .b2_used_o    (b2_used_o)
    );

    // shift booster code down to the fitted stages
    reg [3:0] mult;
    reg [3:0] cap;
    always @* begin
        mult = boost_code_q[2] ? `LCDSUB_BOOST_MAX : {2'b00, boost_code_q[1:0]} + `LCDSUB_BOOST_MIN;
        if (fitted_stages_i < 3'h2)
            cap = `LCDSUB_BOOST_MIN;
        else if (fitted_stages_i > 3'h6)
            cap = `LCDSUB_BOOST_MAX;
        else
            cap = {1'b0, fitted_stages_i};
        // Every code moves down by the missing stages; the lowest codes floor at 2x.
        if (mult + cap < `LCDSUB_BOOST_MAX + `LCDSUB_BOOST_MIN)
            mult = `LCDSUB_BOOST_MIN;
        else
            mult = mult + cap - `LCDSUB_BOOST_MAX;
    end

    // Oscillator status comes from another domain, so it passes two flops first.
    always @(posedge clk_i) begin
        osc_meta_q <= osc_running_i;
        osc_sync_q <= osc_meta_q;
    end

    always @(posedge clk_i) begin
        boost_mult_o <= mult[2:0];
        // supply on enables all three stages with oscillator
        booster_en_o <= supply_on_o && osc_sync_q;
        regulator_en_o <= supply_on_o && osc_sync_q;
        follower_en_o <= supply_on_o && osc_sync_q;
    end

    always @(posedge clk_i) begin
        soft_reset_o <= 1'b0;
        if (!nrst_i || (cmd && !sub_mode_o && b == `LCDSUB_CMD_SOFT_RESET)) begin
            sub_mode_o <= 1'b0;
            soft_reset_o <= nrst_i;
            partial_o <= 1'b0;
            b1_start_o <= 4'h0;
            b1_count_o <= `LCDSUB_FULL_UNITS;
            b2_start_o <= 4'h0;
            b2_count_o <= 5'h00;
            b1s_q <= 4'h0;
            b1c_q <= `LCDSUB_FULL_UNITS;
            b2s_q <= 4'h0;
            b2c_q <= 5'h00;
            contrast_level_setting_o <= `LCDSUB_RST_CONTRAST;
            lvl_pend_q <= `LCDSUB_RST_CONTRAST;
            line_inv_o <= `LCDSUB_RST_LINV;
            linv_pend_q <= `LCDSUB_RST_LINV;
            bias_code_o <= `LCDSUB_RST_BIAS;
            boost_code_q <= `LCDSUB_RST_BOOST;
            rmw_o <= 1'b0;
            column_o <= 8'h00;
            col_save_q <= 8'h00;
            if (!nrst_i) begin
                supply_on_o <= 1'b0;
                wave_on_o <= 1'b0;
            end
        end else begin
            // column steps on writes until 0x83, holds on reads in read-modify-write mode
            if (dat && mem_write_i && column_o != `LCDSUB_LAST_COLUMN)
                column_o <= column_o + 8'h01;
            else if (dat && mem_read_i && !rmw_o && column_o != `LCDSUB_LAST_COLUMN)
                column_o <= column_o + 8'h01;
            if (cmd && sub_mode_o) begin
                if (b == `LCDSUB_CMD_SUB_EXIT)
                    sub_mode_o <= 1'b0;
                // partial display on loads stored blocks
                else if (b == `LCDSUB_CMD_PART_ON) begin
                    partial_o <= 1'b1;
                    b1_start_o <= b1s_q;
                    b1_count_o <= b1c_q;
                    b2_start_o <= b2s_q;
                    b2_count_o <= b2c_q;
                end else if (b == `LCDSUB_CMD_ACTIVATE) begin
                    contrast_level_setting_o <= lvl_pend_q;
                    line_inv_o <= linv_pend_q;
                end else if (b[7:4] == `LCDSUB_HI_B1_START)
                    b1s_q <= b[3:0];
                else if (b[7:5] == `LCDSUB_TOP3_B1_COUNT)
                    b1c_q <= b[4:0];
                else if (b[7:4] == `LCDSUB_HI_B2_START)
                    b2s_q <= b[3:0];
                else if (b[7:5] == `LCDSUB_TOP3_B2_COUNT)
                    b2c_q <= b[4:0];
                else if (b[7:4] == `LCDSUB_HI_LEVEL_UP)
                    lvl_pend_q <= {b[3:0], lvl_pend_q[3:0]};
                else if (b[7:4] == `LCDSUB_HI_LEVEL_LO)
                    lvl_pend_q <= {lvl_pend_q[7:4], b[3:0]};
                else if (b[7:4] == `LCDSUB_HI_LINV)
                    linv_pend_q <= b[3:0];
            end else if (cmd) begin
                if (b == `LCDSUB_CMD_SUB_ENTER)
                    sub_mode_o <= 1'b1;
                else if (b[7:4] == `LCDSUB_HI_BIAS)
                    bias_code_o <= b[3] ? 4'h8 : b[3:0];
                else if (b[7:3] == `LCDSUB_TOP5_BOOST)
                    boost_code_q <= b[2:0];
                else if (b[7:1] == `LCDSUB_TOP7_RMW) begin
                    if (b[0] && rmw_o) begin
                        rmw_o <= 1'b0;
                        column_o <= col_save_q;
                    end else if (!b[0] && !rmw_o) begin
                        rmw_o <= 1'b1;
                        col_save_q <= column_o;
                    end
                end else if (b[7:1] == `LCDSUB_TOP7_SUPPLY)
                    supply_on_o <= b[0];
                else if (b[7:1] == `LCDSUB_TOP7_WAVE)
                    wave_on_o <= b[0];
                else if (b[7:4] == `LCDSUB_CMD_COL_HI && !rmw_o)
                    column_o <= {b[3:0], column_o[3:0]};
                else if (b[7:4] == `LCDSUB_CMD_COL_LO && !rmw_o)
                    column_o <= {column_o[7:4], b[3:0]};
            end
        end
    end
endmodule // lcdsub_decoder

// ===== bench/lcdsub_decoder_properties.sv
/* Port assertions for the sub-table decoder.
   Assumes binding to lcdsub_decoder; one clock, sync active-low reset. */
`timescale 1ns/1ps
module lcdsub_props (
    input wire       clk_i,
    input wire       nrst_i,
    input wire       cmd_valid_i,
    input wire       command_data_select_i,
    input wire       mem_write_i,
    input wire       mem_read_i,
    input wire       sub_mode_o,
    input wire       partial_o,
    input wire       rmw_o,
    input wire       wave_on_o,
    input wire [7:0] cmd_byte_i,
    input wire [7:0] duty_lines_o,
    input wire [7:0] contrast_level_setting_o,
    input wire [7:0] column_o,
    input wire [4:0] active_units_o,
    input wire [3:0] bias_code_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wire cmd_w = cmd_valid_i && !command_data_select_i;
    wire main_w = cmd_w && !sub_mode_o;
    wire sub_w = cmd_w && sub_mode_o;
    wire dat_w = rmw_o && cmd_valid_i && command_data_select_i;
    sub_enter_a: assert property (main_w && cmd_byte_i == 8'h70 |=> sub_mode_o)
        else $error("sub table not entered");
    sub_exit_a: assert property (sub_w && cmd_byte_i == 8'h71 |=> !sub_mode_o)
        else $error("sub table not left");
    part_on_a: assert property (sub_w && cmd_byte_i == 8'h40 |=> partial_o)
        else $error("partial display not on");
    duty_match_a: assert property (duty_lines_o == {active_units_o, 3'h0} &&
        (partial_o || duty_lines_o == 8'h80)) else $error("duty lines differ from units");
    part_bias_a: assert property (sub_w && cmd_byte_i == 8'h40 |=> $stable(bias_code_o))
        else $error("bias moved on partial on");
    level_hold_a: assert property (sub_w && cmd_byte_i[7:5] == 3'h4 |=>
        $stable(contrast_level_setting_o)) else $error("contrast changed early");
    bias_map_a: assert property (main_w && cmd_byte_i[7:4] == 4'hB |=> bias_code_o ==
        ($past(cmd_byte_i[3]) ? 4'h8 : {1'h0, $past(cmd_byte_i[2:0])}))
        else $error("bias code wrong");
    wave_set_a: assert property (main_w && cmd_byte_i[7:1] == 7'h11 |=>
        wave_on_o == $past(cmd_byte_i[0])) else $error("waveform flag wrong");
    rmw_read_a: assert property (dat_w && mem_read_i && !mem_write_i |=>
        $stable(column_o)) else $error("column moved on read");
    rmw_write_a: assert property (dat_w && mem_write_i && column_o < 8'h83 |=>
        column_o == $past(column_o) + 8'h01) else $error("column not advanced");
    soft_rst_a: assert property (main_w && cmd_byte_i == 8'hE2 |=>
        contrast_level_setting_o == 8'hFF && active_units_o == 5'h10)
        else $error("soft reset defaults wrong");
endmodule // lcdsub_props
bind lcdsub_decoder lcdsub_props u_props (.clk_i, .nrst_i, .cmd_valid_i,
    .command_data_select_i, .mem_write_i, .mem_read_i, .sub_mode_o, .partial_o, .rmw_o,
    .wave_on_o, .cmd_byte_i, .duty_lines_o, .contrast_level_setting_o, .column_o,
    .active_units_o, .bias_code_o);

// ===== bench/lcdsub_host.sv
/* Host model that strobes command and data bytes into the decoder.
   Assumes the caller keeps command order and sub-table discipline. */
`timescale 1ns/1ps
module lcdsub_host (
    input  wire        clk_i,
    output logic       valid_o = 1'h0,
    output logic [7:0] byte_o = 8'h00,
    output logic       cds_o = 1'h0,
    output logic       wr_o = 1'h0,
    output logic       rd_o = 1'h0
);
    task xfer(input logic d, input logic w, input logic [7:0] b);
        @(negedge clk_i);
        valid_o = 1'h1;
        byte_o = b;
        cds_o = d;
        wr_o = d & w;
        rd_o = d & !w;
        @(negedge clk_i);
        valid_o = 1'h0;
        byte_o = ~b;
    endtask
endmodule // lcdsub_host

// ===== bench/lcdsub_decoder_tb.sv
/* Self-checking bench for the sub-table decoder.
   Assumes lcdsub_host drives the command port and the checker is bound. */
`timescale 1ns/1ps
module lcdsub_decoder_tb;
    logic       clk_i = 1'h0;
    logic       nrst_i = 1'h0;
    logic       osc_running_i = 1'h1;
    logic [2:0] fitted_stages_i = 3'h6;
    wire        cmd_valid_i, command_data_select_i, mem_write_i, mem_read_i, sub_mode_o;
    wire        partial_o, b2_used_o, rmw_o, supply_on_o, booster_en_o, regulator_en_o;
    wire        follower_en_o, wave_on_o, soft_reset_o;
    wire [7:0]  cmd_byte_i, duty_lines_o, contrast_level_setting_o, column_o;
    wire [4:0]  b1_count_o, b2_count_o, active_units_o, b2_first_page_o;
    wire [3:0]  b1_start_o, b2_start_o, line_inv_o, bias_code_o;
    wire [2:0]  boost_mult_o;
    int         err_count = 0;
    int         n_checks = 0;
    always #5 clk_i = ~clk_i;
    lcdsub_host host (.clk_i, .valid_o(cmd_valid_i), .byte_o(cmd_byte_i),
        .cds_o(command_data_select_i), .wr_o(mem_write_i), .rd_o(mem_read_i));
    lcdsub_decoder uut (.clk_i, .nrst_i, .cmd_valid_i, .cmd_byte_i, .command_data_select_i,
        .mem_write_i, .mem_read_i, .osc_running_i, .fitted_stages_i, .sub_mode_o, .partial_o,
        .b1_start_o, .b1_count_o, .b2_start_o, .b2_count_o, .active_units_o, .duty_lines_o,
        .b2_first_page_o, .b2_used_o, .contrast_level_setting_o, .line_inv_o, .bias_code_o,
        .boost_mult_o, .rmw_o, .column_o, .supply_on_o, .booster_en_o, .regulator_en_o,
        .follower_en_o, .wave_on_o, .soft_reset_o);
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task report_and_stop;
        if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task cmds(input logic [7:0] q[$]);
        foreach (q[i]) host.xfer(1'h0, 1'h0, q[i]);
    endtask
    initial begin
        #20000;
        err_count++;
        report_and_stop;
    end
    initial begin
        repeat (12) @(negedge clk_i);
        nrst_i = 1'h1;
        chk("sub", 8'h00, sub_mode_o);
        chk("duty", 8'h80, duty_lines_o);
        cmds('{8'h70, 8'h00, 8'h22, 8'hC4, 8'hE5, 8'h40});
        chk("duty", 8'h38, duty_lines_o);
        chk("page", 8'h02, b2_first_page_o);
        chk("b2s", 8'h04, b2_start_o);
        chk("b1c", 8'h02, b1_count_o);
        cmds('{8'h00, 8'h30, 8'hC4, 8'hE5, 8'h40});
        chk("units", 8'h10, active_units_o);
        cmds('{8'h00, 8'h22, 8'hC0, 8'hE0, 8'h40});
        chk("used", 8'h00, b2_used_o);
        cmds('{8'h00, 8'h23, 8'hC0, 8'hE0});
        chk("units", 8'h02, active_units_o);
        cmds('{8'h40, 8'h83, 8'h97, 8'h55, 8'hB3});
        chk("units", 8'h03, active_units_o);
        chk("level", 8'hFF, contrast_level_setting_o);
        chk("linv", 8'h00, line_inv_o);
        chk("bias", 8'h08, bias_code_o);
        cmds('{8'hA0, 8'h71});
        chk("level", 8'h37, contrast_level_setting_o);
        chk("linv", 8'h05, line_inv_o);
        chk("sub", 8'h00, sub_mode_o);
        for (int i = 0; i < 16; i++) begin
            cmds('{8'hB0 | 8'(i)});
            chk("bias", i > 7 ? 8'h08 : 8'(i), bias_code_o);
        end
        for (int i = 0; i < 8; i++) begin
            cmds('{8'h28 | 8'(i)});
            @(negedge clk_i);
            chk("boost", i > 3 ? 8'h06 : 8'(i + 2), boost_mult_o);
        end
        fitted_stages_i = 3'h4;
        cmds('{8'h2B});
        @(negedge clk_i);
        chk("boost", 8'h03, boost_mult_o);
        cmds('{8'h23});
        chk("wave", 8'h01, wave_on_o);
        cmds('{8'h22, 8'h25});
        chk("wave", 8'h00, wave_on_o);
        @(negedge clk_i);
        chk("supply", 8'h07, {booster_en_o, regulator_en_o, follower_en_o});
        osc_running_i = 1'h0;
        repeat (3) @(negedge clk_i);
        chk("supply", 8'h00, {booster_en_o, regulator_en_o, follower_en_o});
        osc_running_i = 1'h1;
        cmds('{8'h11, 8'h02, 8'hE8});
        chk("rmw", 8'h01, rmw_o);
        host.xfer(1'h1, 1'h1, 8'h5A);
        chk("col", 8'h13, column_o);
        host.xfer(1'h1, 1'h0, 8'h00);
        cmds('{8'h10, 8'h00});
        chk("col", 8'h13, column_o);
        cmds('{8'hE9, 8'h23});
        chk("col", 8'h12, column_o);
        chk("rmw", 8'h00, rmw_o);
        cmds('{8'hE2});
        chk("soft", 8'hC0, {wave_on_o, bias_code_o, line_inv_o[2:0]});
        chk("srst", 8'h01, soft_reset_o);
        chk("col", 8'h00, column_o);
        host.xfer(1'h1, 1'h0, 8'h00);
        chk("col", 8'h01, column_o);
        cmds('{8'h18, 8'h03});
        host.xfer(1'h1, 1'h1, 8'h00);
        chk("col", 8'h83, column_o);
        cmds('{8'h70});
        nrst_i = 1'h0;
        @(negedge clk_i);
        nrst_i = 1'h1;
        chk("sub", 8'h00, sub_mode_o);
        report_and_stop;
    end
endmodule // lcdsub_decoder_tb
